// [design/gpc_gpio_port.sv]
`timescale 1ns/10ps
`default_nettype none

module gpc_gpio_port #(
    parameter int unsigned HOLD_CYCLES = gpc_pkg::RST_HOLD_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // hard reset pin and stretched reset out
    input wire logic ext_reset_pin_n,
    output var logic module_reset_n,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output var logic [31:0] avs_readdata,
    output var logic avs_waitrequest,
    // header pins
    input wire logic [15:0] pin_in,
    output var gpc_pkg::gpc_pin_drive_t pin_drive,
    // dedicated peripherals
    input wire gpc_pkg::gpc_periph_t periph_drive,
    output var logic [15:0] periph_in,
    input wire logic eth_activity
);
    import gpc_pkg::*;

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic word_hit(input logic [3:0] addr, input logic [3:0] base);
        return addr[3:2] == base[3:2];
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // stretched hard reset
    // ==========================================================
    logic hold_active;

    gpc_reset_stretch #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_reset_stretch (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .reset_pin_n(ext_reset_pin_n),
        .hold_active(hold_active)
    );

    // ==========================================================
    // state
    // ==========================================================
    logic [31:0] port_a_control_reg;
    logic [31:0] port_c_control_reg;
    logic [31:0] ctrl_reg;
    logic init_seen_reg;
    logic led_blink_reg;
    logic wait_reg;
    logic [31:0] readdata_reg;
    logic [15:0] pin_out_reg;
    logic [15:0] pin_oe_n_reg;
    logic [15:0] periph_in_reg;
    logic module_reset_n_reg;

    // ==========================================================
    // bus decode
    // ==========================================================
    wire bus_req = avs_read | avs_write;
    wire wr_commit = avs_write & ~wait_reg;
    wire hit_port_a = word_hit(avs_address, ADDR_PORT_A);
    wire hit_port_c = word_hit(avs_address, ADDR_PORT_C);
    wire hit_status = word_hit(avs_address, ADDR_STATUS);
    wire hit_ctrl = word_hit(avs_address, ADDR_CTRL);

    // whole-word writes are the expected use; byte enables still honoured
    wire [31:0] port_a_wr_val = merge_bytes(port_a_control_reg, avs_writedata, avs_byteenable) & PORT_A_WMASK;
    wire [31:0] port_c_wr_val = merge_bytes(port_c_control_reg, avs_writedata, avs_byteenable) & PORT_C_WMASK;
    wire [31:0] ctrl_wr_val = merge_bytes(ctrl_reg, avs_writedata, avs_byteenable) & 32'h0000_0003;
    wire init_clear = wr_commit & hit_status & avs_byteenable[0] & avs_writedata[STAT_INIT_SEEN];

    // ==========================================================
    // line configuration vectors
    // ==========================================================
    wire [15:0] cfg_mode = {port_c_control_reg[FLD_MODE_LSB +: 8], port_a_control_reg[FLD_MODE_LSB +: 8]};
    wire [15:0] cfg_dir = {port_c_control_reg[FLD_DIR_LSB +: 8], port_a_control_reg[FLD_DIR_LSB +: 8]};
    wire [15:0] cfg_sf = {port_c_control_reg[FLD_SF_LSB +: 8], 8'h00};
    wire [15:0] cfg_data = {port_c_control_reg[FLD_DATA_LSB +: 8], port_a_control_reg[FLD_DATA_LSB +: 8]};

    // auto blink flips the stored level, so the led polarity stays software's
    wire [15:0] led_flip = 16'(led_blink_reg) << (LINES_PER_PORT + LED_LINE);
    wire [15:0] line_level = cfg_data ^ led_flip;

    wire led_auto = ctrl_reg[CTRL_LED_AUTO];
    wire init_pin = pin_in[LINES_PER_PORT + INIT_LINE];
    wire init_match = (init_pin == ctrl_reg[CTRL_INIT_LEVEL]);

    // ==========================================================
    // per-line pin mux
    // ==========================================================
    wire [15:0] line_out_next;
    wire [15:0] line_oe_n_next;

    for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
        // peripheral owns value and direction when the mode bit is set
        wire gp_output = ~cfg_sf[g] & cfg_dir[g];
        wire drive_en = cfg_mode[g] ? periph_drive.oe[g] : gp_output;
        assign line_out_next[g] = cfg_mode[g] ? periph_drive.out[g] : line_level[g];
        // all pins released while the stretched reset holds
        assign line_oe_n_next[g] = hold_active | ~drive_en;
    end

    // ==========================================================
    // read mux
    // ==========================================================
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_port_a) begin
            // data byte shows the pin, not the stored drive value
            rd_mux = {port_a_control_reg[31:8], pin_in[7:0]};
        end else if (hit_port_c) begin
            rd_mux = {port_c_control_reg[31:8], pin_in[15:8]};
        end else if (hit_status) begin
            rd_mux = {~pin_oe_n_reg, 13'h0000, init_seen_reg, init_pin, hold_active};
        end else if (hit_ctrl) begin
            rd_mux = ctrl_reg;
        end
    end

    // ==========================================================
    // avalon handshake
    // ==========================================================
    // one wait cycle per access; idle waitrequest stays high
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~(wait_reg & bus_req);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            readdata_reg <= 32'h0000_0000;
        end else if (wait_reg & avs_read) begin
            readdata_reg <= rd_mux;
        end
    end

    // ==========================================================
    // port and control registers
    // ==========================================================
    // reserved lines are stored like any other; keeping them is software's job
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            port_a_control_reg <= PORT_A_RESET;
            port_c_control_reg <= PORT_C_RESET;
            ctrl_reg <= CTRL_RESET;
        end else if (hold_active) begin
            port_a_control_reg <= PORT_A_RESET;
            port_c_control_reg <= PORT_C_RESET;
            ctrl_reg <= CTRL_RESET;
        end else if (wr_commit) begin
            if (hit_port_a) begin
                port_a_control_reg <= port_a_wr_val;
            end
            if (hit_port_c) begin
                port_c_control_reg <= port_c_wr_val;
            end
            if (hit_ctrl) begin
                ctrl_reg <= ctrl_wr_val;
            end
        end
    end

    // ==========================================================
    // activity led and soft reset watch
    // ==========================================================
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            led_blink_reg <= 1'b0;
        end else if (hold_active | ~led_auto) begin
            led_blink_reg <= 1'b0;
        end else if (eth_activity) begin
            led_blink_reg <= ~led_blink_reg;
        end
    end

    // set wins over a same-cycle clear so no trigger is lost
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            init_seen_reg <= 1'b0;
        end else if (hold_active) begin
            init_seen_reg <= 1'b0;
        end else if (init_match) begin
            init_seen_reg <= 1'b1;
        end else if (init_clear) begin
            init_seen_reg <= 1'b0;
        end
    end

    // ==========================================================
    // registered pin side
    // ==========================================================
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_out_reg <= 16'h0000;
            pin_oe_n_reg <= 16'hffff;
            periph_in_reg <= 16'h0000;
            module_reset_n_reg <= 1'b0;
        end else begin
            pin_out_reg <= line_out_next;
            pin_oe_n_reg <= line_oe_n_next;
            periph_in_reg <= pin_in;
            module_reset_n_reg <= ~hold_active;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign avs_waitrequest = wait_reg;
    assign avs_readdata = readdata_reg;
    assign pin_drive = '{out: pin_out_reg, oe_n: pin_oe_n_reg};
    assign periph_in = periph_in_reg;
    assign module_reset_n = module_reset_n_reg;

endmodule

`default_nettype wire

// [design/gpc_pkg.sv]
package gpc_pkg;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 4;
    localparam int RST_MIN_LOW_NS = 1000;
    // least time: round up to whole cycles
    localparam int RST_MIN_LOW_CYC = (RST_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_HOLD_MS = 250;
    localparam longint RST_HOLD_NS = longint'(RST_HOLD_MS) * 64'd1000000;
    localparam int RST_HOLD_CYC = int'(RST_HOLD_NS / CLK_PERIOD_NS);
    localparam int RST_CNT_W = 26;

    // ==========================================================
    // register map (byte addresses)
    // ==========================================================
    localparam logic [3:0] ADDR_PORT_A = 4'h0;
    localparam logic [3:0] ADDR_PORT_C = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_CTRL = 4'hc;

    // one byte per field, one bit per line inside each byte
    localparam int FLD_DATA_LSB = 0;
    localparam int FLD_SF_LSB = 8;
    localparam int FLD_DIR_LSB = 16;
    localparam int FLD_MODE_LSB = 24;
    localparam int LINES_PER_PORT = 8;
    localparam int NUM_LINES = 16;

    // first port has no special-function byte
    localparam logic [31:0] PORT_A_WMASK = 32'hffff_00ff;
    localparam logic [31:0] PORT_C_WMASK = 32'hffff_ffff;
    // serial and modem lines on their peripheral, line 4 left alone
    localparam logic [31:0] PORT_A_RESET = 32'hef00_0000;
    // activity led line as output, driven high so the led starts dark
    localparam logic [31:0] PORT_C_RESET = 32'h0040_0040;

    localparam int LED_LINE = 6;
    localparam int INIT_LINE = 5;

    localparam int CTRL_LED_AUTO = 0;
    localparam int CTRL_INIT_LEVEL = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    localparam int STAT_HOLD = 0;
    localparam int STAT_INIT_PIN = 1;
    localparam int STAT_INIT_SEEN = 2;
    localparam int STAT_OE_LSB = 16;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [2:0] {
        RST_RUN = 3'b001,
        RST_QUAL = 3'b010,
        RST_HOLD = 3'b100
    } gpc_rst_state_t;

    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe_n;
    } gpc_pin_drive_t;

    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
    } gpc_periph_t;

endpackage

// [design/gpc_reset_stretch.sv]
`timescale 1ns/10ps
`default_nettype none

module gpc_reset_stretch #(
    parameter int unsigned HOLD_CYCLES = gpc_pkg::RST_HOLD_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // external reset pin, active low
    input wire logic reset_pin_n,
    // stretched reset
    output var logic hold_active
);
    import gpc_pkg::*;

    // ==========================================================
    // qualify and stretch
    // ==========================================================
    gpc_rst_state_t state_reg, state_next;
    logic [RST_CNT_W-1:0] cnt_reg, cnt_next;
    logic hold_reg;

    localparam logic [RST_CNT_W-1:0] MIN_LAST = RST_CNT_W'(RST_MIN_LOW_CYC - 1);
    wire [RST_CNT_W-1:0] hold_last = RST_CNT_W'(HOLD_CYCLES - 1);
    wire [RST_CNT_W-1:0] cnt_inc = cnt_reg + 1'b1;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            RST_RUN: begin
                if (!reset_pin_n) begin
                    state_next = RST_QUAL;
                    cnt_next = '0;
                end
            end
            RST_QUAL: begin
                // glitches shorter than the minimum low time are ignored
                if (reset_pin_n) begin
                    state_next = RST_RUN;
                end else if (cnt_reg == MIN_LAST) begin
                    state_next = RST_HOLD;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_inc;
                end
            end
            RST_HOLD: begin
                // count restarts while the pin is still low
                if (!reset_pin_n) begin
                    cnt_next = '0;
                end else if (cnt_reg == hold_last) begin
                    state_next = RST_RUN;
                end else begin
                    cnt_next = cnt_inc;
                end
            end
            default: begin
                state_next = RST_HOLD;
                cnt_next = '0;
            end
        endcase
    end

    // power-up behaves like a released pin
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= RST_HOLD;
            cnt_reg <= '0;
            hold_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            // qualifying a low pin must not reset anything yet
            hold_reg <= (state_next == RST_HOLD);
        end
    end

    assign hold_active = hold_reg;

endmodule

`default_nettype wire

// [tb/gpc_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// host side of the header pins
// ==========================================================
module gpc_host_model (
    // drive from the port block
    input wire gpc_pkg::gpc_pin_drive_t pin_drive,
    // host drive per line
    input wire logic [15:0] host_level,
    input wire logic [15:0] host_oe,
    // resolved pin levels
    output logic [15:0] pin_in
);
    import gpc_pkg::*;
    // lines nobody drives float high through the pull-up
    assign pin_in = (~pin_drive.oe_n & pin_drive.out) | (host_oe & host_level) | (pin_drive.oe_n & ~host_oe);
endmodule

`default_nettype wire

// [tb/gpc_gpio_port_assertions.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// port checker
// ==========================================================
module gpc_gpio_port_assertions #(
    parameter int unsigned HOLD_CYCLES = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // reset pin and stretched reset
    input wire logic ext_reset_pin_n,
    input wire logic module_reset_n,
    // avalon-mm
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins
    input wire logic [15:0] pin_in,
    input wire gpc_pkg::gpc_pin_drive_t pin_drive
);
    import gpc_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [31:0] low_cnt;
    logic [15:0] ext_cnt;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            low_cnt <= 32'h0;
            ext_cnt <= 16'h0;
        end else begin
            low_cnt <= module_reset_n ? 32'h0 : low_cnt + 32'h1;
            ext_cnt <= ext_reset_pin_n ? 16'h0 : ext_cnt + 16'h1;
        end
    end
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
    wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered");
    wait_idle_a: assert property (!avs_read && !avs_write |=> avs_waitrequest) else $error("answer without request");
    hold_release_a: assert property (!module_reset_n ##1 !module_reset_n |-> $past(pin_drive.oe_n) == 16'hffff)
        else $error("pin driven during hold");
    hold_length_a: assert property ($rose(module_reset_n) |-> low_cnt >= HOLD_CYCLES)
        else $error("hold too short");
    ext_filter_a: assert property (module_reset_n && !ext_reset_pin_n && ext_cnt < 16'd240 |=> module_reset_n)
        else $error("spurious hard reset");
    ext_trigger_a: assert property (ext_cnt == 16'd260 |-> !module_reset_n) else $error("hard reset missed");
    out_drive_a: assert property (avs_write && !avs_waitrequest && avs_address[3:2] == 2'd0 && avs_byteenable == 4'hf
        && module_reset_n && !avs_writedata[24] && avs_writedata[16] |-> ##2 !pin_drive.oe_n[0]
        && pin_drive.out[0] == $past(avs_writedata[0], 2)) else $error("output line wrong");
    in_release_a: assert property (avs_write && !avs_waitrequest && avs_address[3:2] == 2'd1 && avs_byteenable == 4'hf
        && module_reset_n && !avs_writedata[29] && !avs_writedata[21] |-> ##2 pin_drive.oe_n[13])
        else $error("input line driven");
    read_pins_a: assert property (avs_read && avs_waitrequest && avs_address[3:2] == 2'd0
        |=> avs_readdata[15:0] == {8'h00, $past(pin_in[7:0])}) else $error("data byte wrong");
endmodule

bind gpc_gpio_port gpc_gpio_port_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.clk_sys(clk_sys), .resetn(resetn),
    .ext_reset_pin_n(ext_reset_pin_n), .module_reset_n(module_reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_drive(pin_drive));

`default_nettype wire

// [tb/gpc_gpio_port_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module gpc_gpio_port_tb_top;
    import gpc_pkg::*;
    localparam int unsigned HOLD = 20;
`define GPC_CHECK(name, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] %s expected %h seen %h", name, exp, got); \
        end \
    end
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ext_reset_pin_n = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic eth_activity = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic module_reset_n;
    logic [15:0] pin_in;
    logic [15:0] periph_in;
    logic [15:0] host_level = 16'hffff;
    logic [15:0] host_oe = 16'h2000;
    gpc_pin_drive_t pin_drive;
    gpc_periph_t periph_drive = '0;
    int num_errors = 0;
    int cmp_count = 0;
    // reference state
    logic [31:0] m_a = 32'hef00_0000;
    logic [31:0] m_c = 32'h0040_0040;
    logic [31:0] m_ctrl = 32'h1;
    logic m_seen = 1'b0;
    logic m_flip = 1'b0;
    logic init_lvl = 1'b1;

    always #2 clk_sys = ~clk_sys;

    gpc_gpio_port #(.HOLD_CYCLES(HOLD)) dut (.clk_sys(clk_sys), .resetn(resetn), .ext_reset_pin_n(ext_reset_pin_n),
        .module_reset_n(module_reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_drive(pin_drive), .periph_drive(periph_drive),
        .periph_in(periph_in), .eth_activity(eth_activity));
    gpc_host_model host (.pin_drive(pin_drive), .host_level(host_level), .host_oe(host_oe), .pin_in(pin_in));

    // ==========================================================
    // reference model and bus tasks
    // ==========================================================
    function automatic logic [47:0] model_pins();
        logic [31:0] r;
        logic [15:0] oen;
        logic [15:0] outv;
        logic [15:0] lvl;
        for (int n = 0; n < 16; n++) begin
            r = (n < 8) ? m_a : m_c;
            oen[n] = 1'b1;
            outv[n] = 1'b0;
            if (r[24 + n % 8]) begin
                oen[n] = ~periph_drive.oe[n];
                outv[n] = periph_drive.out[n];
            end else if (r[16 + n % 8] && !(n >= 8 && r[8 + n % 8])) begin
                oen[n] = 1'b0;
                outv[n] = r[n % 8] ^ (n == 14 && m_flip);
            end
            lvl[n] = !oen[n] ? outv[n] : (host_oe[n] ? host_level[n] : 1'b1);
        end
        return {lvl, oen, outv};
    endfunction

    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_write <= wr_en;
        avs_read <= !wr_en;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        `GPC_CHECK("answer", 1'b0, avs_waitrequest)
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        logic [31:0] lane;
        bus(1'b1, a, d, be, q);
        lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        if (a[3:2] == 2'd0) m_a = (m_a & ~(lane & 32'hffff_00ff)) | (d & lane & 32'hffff_00ff);
        if (a[3:2] == 2'd1) m_c = (m_c & ~lane) | (d & lane);
        if (a[3:2] == 2'd2 && be[0] && d[2]) m_seen = 1'b0;
        if (a[3:2] == 2'd3) m_ctrl = ((m_ctrl & ~lane) | (d & lane)) & 32'h3;
        if (!m_ctrl[0]) m_flip = 1'b0;
    endtask

    task automatic check_pins();
        logic [47:0] m;
        logic [31:0] q;
        m = model_pins();
        // host only drives lines the block has released
        host_oe <= m[31:16] & (16'($urandom) | 16'h2000);
        host_level <= (16'($urandom) & 16'hdfff) | {2'b00, init_lvl, 13'h0};
        repeat (4) @(posedge clk_sys);
        m = model_pins();
        m_seen = m_seen | (m[45] == m_ctrl[1]);
        `GPC_CHECK("oe_n", m[31:16], pin_drive.oe_n)
        `GPC_CHECK("out", m[15:0] & ~m[31:16], pin_drive.out & ~m[31:16])
        bus(1'b0, ADDR_PORT_A | 4'($urandom_range(3)), 32'h0, 4'h0, q);
        `GPC_CHECK("port_a", {m_a[31:16], 8'h00, m[39:32]}, q)
        bus(1'b0, ADDR_PORT_C, 32'h0, 4'h0, q);
        `GPC_CHECK("port_c", {m_c[31:8], m[47:40]}, q)
        bus(1'b0, ADDR_STATUS, 32'h0, 4'h0, q);
        `GPC_CHECK("status", {~m[31:16], 13'h0, m_seen, m[45], 1'b0}, q)
        bus(1'b0, ADDR_CTRL, 32'h0, 4'h0, q);
        `GPC_CHECK("ctrl", m_ctrl, q)
        `GPC_CHECK("periph_in", m[47:32], periph_in)
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    initial begin
        logic [31:0] d;
        logic [31:0] q;
        int n;
        void'($urandom(98145));
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (HOLD - 2) @(posedge clk_sys);
        `GPC_CHECK("held", 1'b0, module_reset_n)
        `GPC_CHECK("hold_oe", 16'hffff, pin_drive.oe_n)
        repeat (12) @(posedge clk_sys);
        `GPC_CHECK("run", 1'b1, module_reset_n)
        check_pins();
        // reserved lines keep their value in every read-modify-write
        for (int i = 0; i < 40; i++) begin
            periph_drive <= $urandom;
            d = $urandom;
            wr(ADDR_PORT_A | 4'($urandom_range(3)), (m_a & 32'h1010_1010) | (d & ~32'h1010_1010),
                i[0] ? 4'hf : 4'($urandom));
            wr(ADDR_PORT_C, (m_c & 32'hbfbf_bfbf) | (d & ~32'hbfbf_bfbf), 4'hf);
            check_pins();
        end
        wr(ADDR_PORT_C, (m_c & 32'hbfbf_bfbf) | 32'h0040_0000, 4'hf);
        for (int j = 0; j < 2; j++) begin
            n = $urandom_range(5, 1);
            for (int k = 0; k < n; k++) begin
                @(posedge clk_sys) eth_activity <= 1'b1;
                @(posedge clk_sys) eth_activity <= 1'b0;
            end
            if (m_ctrl[0]) m_flip = m_flip ^ n[0];
            check_pins();
            wr(ADDR_CTRL, 32'h0, 4'hf);
        end
        `GPC_CHECK("led_lit", 1'b0, pin_drive.out[14])
        wr(ADDR_PORT_C, m_c | 32'h0020_0020, 4'hf);
        check_pins();
        wr(ADDR_PORT_C, m_c & ~32'h2020_2020, 4'hf);
        for (int s = 0; s < 5; s++) begin
            init_lvl = (s != 0);
            wr(ADDR_CTRL, {30'h0, s[1] && s < 4, 1'b1}, 4'hf);
            check_pins();
            if (s[0] || s == 4) wr(ADDR_STATUS, 32'h4, 4'h1);
            check_pins();
        end
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_sys) ext_reset_pin_n <= 1'b0;
            repeat (s ? 300 : 100) @(posedge clk_sys);
            `GPC_CHECK("ext_hold", s == 0, module_reset_n)
            if (s) begin
                `GPC_CHECK("ext_oe", 16'hffff, pin_drive.oe_n)
                bus(1'b0, ADDR_STATUS, 32'h0, 4'h0, q);
                `GPC_CHECK("hold_stat", 17'h0_0001, {q[31:16], q[0]})
            end
            ext_reset_pin_n <= 1'b1;
            repeat (HOLD + 20) @(posedge clk_sys);
            if (s) begin
                m_a = 32'hef00_0000;
                m_c = 32'h0040_0040;
                m_ctrl = 32'h1;
                m_flip = 1'b0;
                m_seen = 1'b0;
            end
            check_pins();
        end
        complete_run();
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        num_errors++;
        complete_run();
    end
endmodule

`default_nettype wire
